// >>> twc_pkg.sv
// Constants for the two-wire controller/target register unit.
// Assumes a single core clock; bit phases are counted in divider ticks of div+1 core clock cycles.
package twc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_TOWN = 12'h000;
    localparam logic [11:0] OFF_TSTC = 12'h004;
    localparam logic [11:0] OFF_TDAT = 12'h008;
    localparam logic [11:0] OFF_TMSK = 12'h00c;
    localparam logic [11:0] OFF_TRAW = 12'h010;
    localparam logic [11:0] OFF_TARGET_IRQ_MASKED = 12'h014;
    localparam logic [11:0] OFF_TCLR = 12'h018;
    localparam logic [11:0] OFF_CTA = 12'h800;
    localparam logic [11:0] OFF_CSTC = 12'h804;
    localparam logic [11:0] OFF_CDAT = 12'h808;
    localparam logic [11:0] OFF_CDIV = 12'h80c;
    localparam logic [11:0] OFF_CMSK = 12'h810;
    localparam logic [11:0] OFF_CRAW = 12'h814;
    localparam logic [11:0] OFF_CONTROLLER_IRQ_MASKED = 12'h818;
    localparam logic [11:0] OFF_CCLR = 12'h81c;
    localparam logic [11:0] OFF_CFG = 12'h820;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_RUN = 0;
    localparam int CMD_START = 1;
    localparam int CMD_STOP = 2;
    localparam int CTA_DIR = 0;
    localparam int CFG_LOOP = 0;
    localparam int CFG_CTL_EN = 4;
    localparam int CFG_TGT_EN = 5;
    localparam int TARGET_CONTROL_ACT = 0;
    // ------------------------------------------------------------
    // Reset values and bit timing
    // ------------------------------------------------------------
    localparam logic [31:0] RST_CONTROLLER_STATUS_ALIAS = 32'h00000020;
    localparam logic [7:0] RST_DIV = 8'h01;
    localparam int CLOCK_LOW_PHASE = 6;
    localparam int CLOCK_HIGH_PHASE = 4;
    localparam logic [4:0] PH_LOW = 5'(2 * CLOCK_LOW_PHASE);
    localparam logic [4:0] PH_LAST = 5'(2 * (CLOCK_LOW_PHASE + CLOCK_HIGH_PHASE) - 1);
    localparam logic [4:0] PH_CHG = 5'(CLOCK_LOW_PHASE);
    localparam logic [4:0] PH_SMP = 5'(2 * CLOCK_LOW_PHASE + CLOCK_HIGH_PHASE);
    localparam logic [4:0] PH_HALF = 5'(CLOCK_LOW_PHASE + CLOCK_HIGH_PHASE);
    localparam logic [3:0] ACK_BIT = 4'h8;
    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {C_IDLE, C_START, C_BYTE, C_STOP} twc_cst_t;
    typedef enum logic [2:0] {
        T_IDLE, T_ADDR, T_AACK, T_RX, T_RACK, T_TX, T_TACK, T_WAIT
    } twc_tst_t;
endpackage : twc_pkg

// >>> twc_top.sv
// Two-wire bus unit: controller and target halves behind one register port.
// Assumes a plain strobe register port and open-drain pads outside.
//
// How it works
// - divider sets system clocks per serial clock
// - period is 2*(div+1)*(6+4) core clocks
// - address register: seven bits above direction
// - direction bit set means receive
// - command 7 sends or receives one byte then stop
// - bus busy flag at status bit 6
// - status bit 1 flags missing acknowledge
// - controller data sends or captures byte
// - own-address register holds seven bits
// - target data returns or captures byte
// - mask bits gate raw events to interrupt
// - target masked equals raw AND mask
// - controller masked equals raw AND mask
// - target clear register clears raw bits
// - controller clear clears raw and masked
// - offset 4h: status read, control write
// - offset 804h: status read, command write
// - status resets to 0x20, others except divider zero
// - divider resets to one
// - configuration selects role and loopback
// - configuration bit 0 ties lines internally
// - completion, arbitration loss, error raise event
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module twc_top
    import twc_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_SRST,
    input wire logic [11:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output logic O_IRQ,
    input wire logic I_SCL_I,
    output logic O_SCL_O,
    output logic O_SCL_OE_N,
    input wire logic I_SDA_I,
    output logic O_SDA_O,
    output logic O_SDA_OE_N
);
    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction : hit

    wire w_town = I_WR && hit(I_ADDR, OFF_TOWN);
    wire w_target_control = I_WR && hit(I_ADDR, OFF_TSTC);
    wire w_tdat = I_WR && hit(I_ADDR, OFF_TDAT);
    wire r_tdat = I_RD && hit(I_ADDR, OFF_TDAT);
    wire w_tmsk = I_WR && hit(I_ADDR, OFF_TMSK);
    wire w_tclr = I_WR && hit(I_ADDR, OFF_TCLR);
    wire w_cta = I_WR && hit(I_ADDR, OFF_CTA);
    wire w_cmd = I_WR && hit(I_ADDR, OFF_CSTC);
    wire w_cdat = I_WR && hit(I_ADDR, OFF_CDAT);
    wire w_cdiv = I_WR && hit(I_ADDR, OFF_CDIV);
    wire w_cmsk = I_WR && hit(I_ADDR, OFF_CMSK);
    wire w_cclr = I_WR && hit(I_ADDR, OFF_CCLR);
    wire w_cfg = I_WR && hit(I_ADDR, OFF_CFG);

    logic [6:0] town_q;
    logic target_control_q;
    logic [7:0] tdat_q, cta_q, cdat_q, div_q;
    logic [2:0] tmsk_q, traw_q;
    logic cmsk_q, craw_q;
    logic [5:0] cfg_q;
    logic [31:0] rd_d;
    wire loop = cfg_q[CFG_LOOP];

    // ------------------------------------------------------------
    // Bus line view, with internal loopback
    // ------------------------------------------------------------
    logic c_scl_q, c_sda_q, t_sda_q, scl_s_q, sda_s_q;
    // In loopback the pads are ignored and both halves share the lines
    wire scl_bus = !c_scl_q && (loop || I_SCL_I);
    wire sda_bus = !c_sda_q && !t_sda_q && (loop || I_SDA_I);
    wire scl_r = scl_bus && !scl_s_q;
    wire scl_f = !scl_bus && scl_s_q;
    wire bstart = scl_bus && scl_s_q && sda_s_q && !sda_bus;
    wire bstop = scl_bus && scl_s_q && !sda_s_q && sda_bus;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            scl_s_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_s_q <= scl_bus;
            sda_s_q <= sda_bus;
        end
    end

    // ------------------------------------------------------------
    // Serial clock divider
    // ------------------------------------------------------------
    twc_cst_t cst;
    logic [7:0] dcnt_q;
    logic [4:0] ph_q;
    logic [3:0] cbit_q;
    wire tick = dcnt_q == div_q;
    wire last = ph_q == PH_LAST;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST || cst == C_IDLE || tick)
            dcnt_q <= 8'h00;
        else
            dcnt_q <= dcnt_q + 8'h01;
    end

    // ------------------------------------------------------------
    // Controller sequencer
    // ------------------------------------------------------------
    logic [7:0] csh_q;
    logic adr_q, crun_q, cstop_q, rw_q, own_q, obit_q;
    logic err_a_q, err_d_q, arb_q, bbsy_q, cbusy_q;
    wire txb = adr_q || !rw_q;
    wire c_cap = tick && last && cst == C_BYTE && cbit_q == ACK_BIT && !adr_q && rw_q;
    wire cdone = cbusy_q && cst == C_IDLE;
    wire c_scl_d = (cst == C_BYTE || cst == C_STOP) ? ph_q < PH_LOW
                 : (cst == C_IDLE && own_q);
    wire c_sda_d = (cst == C_START) ? ph_q >= PH_HALF
                 : (cst == C_BYTE) ? obit_q
                 : (cst == C_STOP) ? ph_q < PH_SMP : 1'b0;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            cst <= C_IDLE;
            ph_q <= 5'h00;
            cbit_q <= 4'h0;
            csh_q <= 8'h00;
            {adr_q, crun_q, cstop_q, rw_q, own_q, obit_q} <= 6'h00;
            {err_a_q, err_d_q, arb_q} <= 3'h0;
        end else if (cst == C_IDLE) begin
            ph_q <= 5'h00;
            cbit_q <= 4'h0;
            obit_q <= 1'b0;
            if (w_cmd && cfg_q[CFG_CTL_EN]) begin
                crun_q <= I_WDATA[CMD_RUN];
                cstop_q <= I_WDATA[CMD_STOP];
                rw_q <= cta_q[CTA_DIR];
                {err_a_q, err_d_q, arb_q} <= 3'h0;
                if (I_WDATA[CMD_START]) begin
                    cst <= C_START;
                    csh_q <= cta_q;
                    adr_q <= 1'b1;
                end else if (I_WDATA[CMD_RUN]) begin
                    cst <= C_BYTE;
                    csh_q <= cdat_q;
                    adr_q <= 1'b0;
                end else if (I_WDATA[CMD_STOP]) begin
                    cst <= C_STOP;
                end
            end
        end else if (tick) begin
            ph_q <= last ? 5'h00 : ph_q + 5'h01;
            unique case (cst)
                C_START: if (last) begin
                    cst <= C_BYTE;
                    own_q <= 1'b1;
                    obit_q <= 1'b1;
                end
                C_BYTE: begin
                    // Data only moves while the clock is low
                    if (ph_q == PH_CHG)
                        obit_q <= (cbit_q != ACK_BIT) ? txb && !csh_q[7]
                                                      : !txb && !cstop_q;
                    if (ph_q == PH_SMP && cbit_q != ACK_BIT) begin
                        csh_q <= {csh_q[6:0], sda_bus};
                        if (txb && csh_q[7] && !sda_bus) begin
                            arb_q <= 1'b1;
                            own_q <= 1'b0;
                            cst <= C_IDLE;
                        end
                    end else if (ph_q == PH_SMP && txb && sda_bus) begin
                        if (adr_q)
                            err_a_q <= 1'b1;
                        else
                            err_d_q <= 1'b1;
                        cst <= C_STOP;
                        ph_q <= 5'h00;
                    end else if (last) begin
                        if (cbit_q != ACK_BIT) begin
                            cbit_q <= cbit_q + 4'h1;
                        end else begin
                            cbit_q <= 4'h0;
                            if (adr_q && crun_q) begin
                                adr_q <= 1'b0;
                                csh_q <= cdat_q;
                            end else begin
                                cst <= cstop_q ? C_STOP : C_IDLE;
                            end
                        end
                    end
                end
                C_STOP: if (last) begin
                    cst <= C_IDLE;
                    own_q <= 1'b0;
                end
                C_IDLE: ;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            c_scl_q <= 1'b0;
            c_sda_q <= 1'b0;
            cbusy_q <= 1'b0;
            bbsy_q <= 1'b0;
        end else begin
            c_scl_q <= c_scl_d;
            c_sda_q <= c_sda_d;
            cbusy_q <= cst != C_IDLE;
            if (bstart)
                bbsy_q <= 1'b1;
            else if (bstop)
                bbsy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Target responder
    // ------------------------------------------------------------
    twc_tst_t tst;
    logic [7:0] tsh_q;
    logic [3:0] tcnt_q;
    logic tnack_q, tfirst_q, tdev_q, rreq_q, treq_q, fbr_q;
    wire t_on = cfg_q[CFG_TGT_EN] && target_control_q;
    wire t_cap = scl_f && tst == T_RX && tcnt_q == ACK_BIT;
    wire t_shift = tst == T_ADDR || tst == T_RX || tst == T_TX;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            tst <= T_IDLE;
            tsh_q <= 8'h00;
            tcnt_q <= 4'h0;
            {tnack_q, tfirst_q, tdev_q, t_sda_q} <= 4'h0;
            {rreq_q, treq_q, fbr_q} <= 3'h0;
        end else begin
            tdev_q <= 1'b0;
            if (r_tdat) begin
                rreq_q <= 1'b0;
                fbr_q <= 1'b0;
            end
            if (w_tdat)
                treq_q <= 1'b0;
            if (bstop) begin
                tst <= T_IDLE;
                t_sda_q <= 1'b0;
            end else if (bstart) begin
                tst <= T_ADDR;
                tcnt_q <= 4'h0;
                t_sda_q <= 1'b0;
            end else if (scl_r) begin
                if (t_shift && tcnt_q != ACK_BIT) begin
                    tsh_q <= {tsh_q[6:0], sda_bus};
                    tcnt_q <= tcnt_q + 4'h1;
                end
                if (tst == T_TACK)
                    tnack_q <= sda_bus;
            end else if (scl_f) begin
                unique case (tst)
                    T_ADDR: if (tcnt_q == ACK_BIT) begin
                        if (t_on && tsh_q[7:1] == town_q) begin
                            t_sda_q <= 1'b1;
                            tst <= T_AACK;
                        end else begin
                            tst <= T_WAIT;
                        end
                    end
                    T_AACK: begin
                        tcnt_q <= 4'h0;
                        if (tsh_q[0]) begin
                            tst <= T_TX;
                            tsh_q <= tdat_q;
                            t_sda_q <= !tdat_q[7];
                            treq_q <= 1'b1;
                            tdev_q <= 1'b1;
                        end else begin
                            tst <= T_RX;
                            t_sda_q <= 1'b0;
                            tfirst_q <= 1'b1;
                        end
                    end
                    T_RX: if (tcnt_q == ACK_BIT) begin
                        rreq_q <= 1'b1;
                        fbr_q <= tfirst_q;
                        tfirst_q <= 1'b0;
                        tdev_q <= 1'b1;
                        t_sda_q <= 1'b1;
                        tst <= T_RACK;
                    end
                    T_RACK: begin
                        t_sda_q <= 1'b0;
                        tcnt_q <= 4'h0;
                        tst <= T_RX;
                    end
                    T_TX: if (tcnt_q == ACK_BIT) begin
                        t_sda_q <= 1'b0;
                        tst <= T_TACK;
                    end else begin
                        t_sda_q <= !tsh_q[7];
                    end
                    T_TACK: if (!tnack_q) begin
                        tst <= T_TX;
                        tcnt_q <= 4'h0;
                        tsh_q <= tdat_q;
                        t_sda_q <= !tdat_q[7];
                        treq_q <= 1'b1;
                        tdev_q <= 1'b1;
                    end else begin
                        tst <= T_WAIT;
                    end
                    T_IDLE, T_WAIT: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers and event flags
    // ------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            town_q <= 7'h00;
            target_control_q <= 1'b0;
            tdat_q <= 8'h00;
            tmsk_q <= 3'h0;
            traw_q <= 3'h0;
            cta_q <= 8'h00;
            cdat_q <= 8'h00;
            div_q <= RST_DIV;
            cmsk_q <= 1'b0;
            craw_q <= 1'b0;
            cfg_q <= 6'h00;
        end else begin
            if (w_town)
                town_q <= I_WDATA[6:0];
            if (w_target_control)
                target_control_q <= I_WDATA[TARGET_CONTROL_ACT];
            if (t_cap)
                tdat_q <= tsh_q;
            else if (w_tdat)
                tdat_q <= I_WDATA[7:0];
            if (w_tmsk)
                tmsk_q <= I_WDATA[2:0];
            // A new event wins over a clear in the same cycle
            traw_q <= (traw_q & ~(w_tclr ? I_WDATA[2:0] : 3'h0))
                    | {bstop, bstart, tdev_q};
            if (w_cta)
                cta_q <= I_WDATA[7:0];
            if (c_cap)
                cdat_q <= csh_q;
            else if (w_cdat)
                cdat_q <= I_WDATA[7:0];
            if (w_cdiv)
                div_q <= I_WDATA[7:0];
            if (w_cmsk)
                cmsk_q <= I_WDATA[0];
            craw_q <= (craw_q && !(w_cclr && I_WDATA[0])) || cdone;
            if (w_cfg)
                cfg_q <= I_WDATA[5:0];
        end
    end

    // ------------------------------------------------------------
    // Read mux and registered outputs
    // ------------------------------------------------------------
    wire [6:0] controller_status_alias = {bbsy_q, cst == C_IDLE, arb_q, err_d_q, err_a_q,
                        err_a_q || err_d_q, cst != C_IDLE};

    always_comb begin
        rd_d = 32'h00000000;
        unique case (I_ADDR)
            OFF_TOWN: rd_d[6:0] = town_q;
            OFF_TSTC: rd_d[2:0] = {fbr_q, treq_q, rreq_q};
            OFF_TDAT: rd_d[7:0] = tdat_q;
            OFF_TMSK: rd_d[2:0] = tmsk_q;
            OFF_TRAW: rd_d[2:0] = traw_q;
            OFF_TARGET_IRQ_MASKED: rd_d[2:0] = traw_q & tmsk_q;
            OFF_CTA: rd_d[7:0] = cta_q;
            OFF_CSTC: rd_d[6:0] = controller_status_alias;
            OFF_CDAT: rd_d[7:0] = cdat_q;
            OFF_CDIV: rd_d[7:0] = div_q;
            OFF_CMSK: rd_d[0] = cmsk_q;
            OFF_CRAW: rd_d[0] = craw_q;
            OFF_CONTROLLER_IRQ_MASKED: rd_d[0] = craw_q && cmsk_q;
            OFF_CFG: rd_d[5:0] = cfg_q;
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SRST) begin
            O_RDATA <= 32'h00000000;
            O_IRQ <= 1'b0;
            O_SCL_O <= 1'b0;
            O_SDA_O <= 1'b0;
            O_SCL_OE_N <= 1'b1;
            O_SDA_OE_N <= 1'b1;
        end else begin
            O_RDATA <= I_RD ? rd_d : 32'h00000000;
            O_IRQ <= (craw_q && cmsk_q) || |(traw_q & tmsk_q);
            O_SCL_OE_N <= !(c_scl_q && !loop);
            O_SDA_OE_N <= !((c_sda_q || t_sda_q) && !loop);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_tick;
        @(posedge I_CORE_CLK) disable iff (I_SRST)
        (tick && div_q == RST_DIV && cst != C_IDLE && !last) |=> !tick ##1 tick;
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing wrong");

    property p_low;
        @(posedge I_CORE_CLK) disable iff (I_SRST)
        (cst == C_BYTE && tick && ph_q == PH_LOW - 5'h01) |=> ##1 !c_scl_q;
    endproperty
    a_low: assert property (p_low) else $error("clock low phase length");

    property p_bbsy;
        @(posedge I_CORE_CLK) disable iff (I_SRST)
        (bstart && !bstop) |=> controller_status_alias[6];
    endproperty
    a_bbsy: assert property (p_bbsy) else $error("bus busy not set");

    property p_nack;
        @(posedge I_CORE_CLK) disable iff (I_SRST)
        (cst == C_BYTE && tick && ph_q == PH_SMP && cbit_q == ACK_BIT && txb && sda_bus)
        |=> controller_status_alias[1] && cst == C_STOP;
    endproperty
    a_nack: assert property (p_nack) else $error("missing ack not flagged");

    property p_controller_irq_masked;
        @(posedge I_CORE_CLK) disable iff (I_SRST)
        (I_RD && I_ADDR == OFF_CONTROLLER_IRQ_MASKED) |=> O_RDATA[0] == ($past(craw_q) && $past(cmsk_q));
    endproperty
    a_controller_irq_masked: assert property (p_controller_irq_masked) else $error("masked status wrong");

    property p_cclr;
        @(posedge I_CORE_CLK) disable iff (I_SRST)
        (w_cclr && I_WDATA[0] && !cdone) |=> !craw_q;
    endproperty
    a_cclr: assert property (p_cclr) else $error("clear did not clear");

    property p_match;
        @(posedge I_CORE_CLK) disable iff (I_SRST)
        $rose(tst == T_AACK) |-> tsh_q[7:1] == town_q && t_sda_q;
    endproperty
    a_match: assert property (p_match) else $error("ack to foreign address");

    property p_irq;
        @(posedge I_CORE_CLK) disable iff (I_SRST)
        (craw_q && !cmsk_q && (traw_q & tmsk_q) == 3'h0) ##1 (tmsk_q == $past(tmsk_q))
        |-> !O_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("masked event reached irq");

    property p_rst;
        @(posedge I_CORE_CLK)
        $fell(I_SRST) |-> div_q == RST_DIV && controller_status_alias == RST_CONTROLLER_STATUS_ALIAS[6:0];
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule : twc_top
`default_nettype wire

// >>> twc_bus_target.sv
// Behavioural bus target on the two-wire lines, write direction only.
// Assumes pull-ups on both lines; it only ever pulls data low to acknowledge.
`timescale 1ns/100ps
`default_nettype none
module twc_bus_target #(
    parameter logic [6:0] ADDR = 7'h3b
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_rel,
    output logic [7:0] got_addr,
    output logic [7:0] got_data
);
    logic act = 1'b0;
    logic hit = 1'b0;
    logic [7:0] sr = 8'h00;
    int nbit = 0;
    int nbyte = 0;
    initial sda_rel = 1'b1;
    initial got_addr = 8'h00;
    initial got_data = 8'h00;
    // Start and stop are data edges while the clock is high
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        hit = 1'b0;
        nbit = 0;
        nbyte = 0;
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    always @(posedge scl) if (act && nbit < 8) begin
        sr = {sr[6:0], sda};
        nbit = nbit + 1;
    end
    // Acknowledge only its own address and the bytes that follow it
    always @(negedge scl) if (act) begin
        if (nbit == 8) begin
            if (nbyte == 0) begin
                got_addr = sr;
                hit = (sr[7:1] == ADDR);
            end else begin
                got_data = sr;
            end
            sda_rel = !hit;
            nbit = 9;
        end else if (nbit == 9) begin
            sda_rel = 1'b1;
            nbit = 0;
            nbyte = nbyte + 1;
        end
    end
endmodule : twc_bus_target
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for twc_top: register port plus one bus target model.
// Assumes pull-ups on both lines; read notes are compared by a monitor.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import twc_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rd_pend = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, pk, x;
    logic irq, scl_oe_n, sda_oe_n, sda_rel, scl_o, sda_o;
    logic [7:0] got_a, got_d;
    wire logic scl_w = scl_oe_n;
    wire logic sda_w = sda_oe_n & sda_rel;
    int bad_count = 0, checked = 0, cyc = 0, t0, i;
    logic [31:0] exp_q[$];
    logic [11:0] ra[17] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
        12'h018, 12'h800, 12'h804, 12'h808, 12'h80c, 12'h810, 12'h814, 12'h818,
        12'h81c, 12'h820, 12'h024};
    logic [11:0] wa[7] = '{12'h000, 12'h00c, 12'h800, 12'h808, 12'h80c, 12'h810, 12'h820};
    logic [31:0] wm[7] = '{32'h7f, 32'h7, 32'hff, 32'hff, 32'hff, 32'h1, 32'h3f};
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    twc_top u_dut (.I_CORE_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_SCL_I(scl_w), .O_SCL_O(scl_o),
        .O_SCL_OE_N(scl_oe_n), .I_SDA_I(sda_w), .O_SDA_O(sda_o), .O_SDA_OE_N(sda_oe_n));
    twc_bus_target u_tgt (.scl(scl_w), .sda(sda_w), .sda_rel(sda_rel), .got_addr(got_a),
        .got_data(got_d));
    task check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_pend <= rd;
        if (rd_pend && exp_q.size() > 0) check(rdata, exp_q.pop_front());
    end
    task wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    task peek(input logic [11:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        pk = rdata;
    endtask : peek
    task xfer(input logic [7:0] dv, input logic [7:0] ta, input logic [7:0] d, input bit lp);
        wr_reg(OFF_CDIV, {24'h0, dv});
        wr_reg(OFF_CTA, {24'h0, ta});
        wr_reg(OFF_CDAT, {24'h0, d});
        wr_reg(OFF_CSTC, 32'h7);
        if (lp) begin
            repeat (100) @(posedge clk);
            check({28'h0, scl_o, sda_o, scl_oe_n, sda_oe_n}, 32'h3);
        end else begin
            @(posedge scl_w) t0 = cyc;
            @(posedge scl_w) check(32'(cyc - t0), 32'(20 * (dv + 1)));
        end
        peek(OFF_CSTC);
        check({31'h0, pk[6]}, 32'h1);
        for (i = 0; i < 5000; i++) begin
            peek(OFF_CSTC);
            if (pk[6] === 1'b0) break;
        end
        check(32'(i < 5000), 32'h1);
        // Bus busy drops at the stop condition, a few ticks before the sequencer idles
        repeat (5 * (dv + 1)) @(posedge clk);
    endtask : xfer
    task end_sim;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    initial begin
        x = $urandom(37);
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int k = 0; k < 17; k++) rd_reg(ra[k], (ra[k] == OFF_CSTC) ? RST_CONTROLLER_STATUS_ALIAS :
            (ra[k] == OFF_CDIV) ? 32'(RST_DIV) : 32'h0);
        for (int k = 0; k < 7; k++) begin
            x = $urandom();
            wr_reg(wa[k], x);
            rd_reg(wa[k], x & wm[k]);
        end
        wr_reg(OFF_TARGET_IRQ_MASKED, x);
        wr_reg(OFF_TMSK, 32'h0);
        rd_reg(OFF_TARGET_IRQ_MASKED, 32'h0);
        // Reserved offsets are only ever read, never written
        rd_reg(12'h024, 32'h0);
        // Transmit to the model at the documented rate, then a refused address
        wr_reg(OFF_CFG, 32'h10);
        wr_reg(OFF_CMSK, 32'h1);
        x = 32'($urandom() % 256);
        xfer(8'd23, 8'h76, x[7:0], 1'b0);
        rd_reg(OFF_CSTC, RST_CONTROLLER_STATUS_ALIAS);
        check({24'h0, got_a}, 32'h76);
        check({24'h0, got_d}, x);
        rd_reg(OFF_CRAW, 32'h1);
        rd_reg(OFF_CONTROLLER_IRQ_MASKED, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr_reg(OFF_CMSK, 32'h0);
        rd_reg(OFF_CONTROLLER_IRQ_MASKED, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr_reg(OFF_CCLR, 32'h1);
        rd_reg(OFF_CRAW, 32'h0);
        xfer(8'd1, 8'h50, x[7:0], 1'b0);
        rd_reg(OFF_CSTC, 32'h26);
        rd_reg(OFF_CRAW, 32'h1);
        wr_reg(OFF_CCLR, 32'h1);
        // Loopback to the unit's own target half
        wr_reg(OFF_CFG, 32'h31);
        wr_reg(OFF_TOWN, 32'h3b);
        wr_reg(OFF_TSTC, 32'h1);
        wr_reg(OFF_TMSK, 32'h1);
        xfer(8'd1, 8'h76, ~x[7:0], 1'b1);
        check({24'h0, got_a}, 32'h50);
        rd_reg(OFF_CSTC, RST_CONTROLLER_STATUS_ALIAS);
        rd_reg(OFF_TRAW, 32'h7);
        rd_reg(OFF_TARGET_IRQ_MASKED, 32'h1);
        check({31'h0, irq}, 32'h1);
        rd_reg(OFF_TSTC, 32'h5);
        rd_reg(OFF_TDAT, {24'h0, ~x[7:0]});
        rd_reg(OFF_TSTC, 32'h0);
        // Read back from the own target half: the captured byte replaces the data register
        xfer(8'd1, 8'h77, x[7:0], 1'b1);
        rd_reg(OFF_CDAT, {24'h0, ~x[7:0]});
        rd_reg(OFF_TSTC, 32'h2);
        wr_reg(OFF_TCLR, 32'h7);
        rd_reg(OFF_TRAW, 32'h0);
        check({31'h0, irq}, 32'h0);
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
